// ==== hw/host_mode_pkg.sv ====
// host interface front end: shared types and constants
// assumes a 10 MHz system clock; pin levels arrive unsynchronised
package host_mode_pkg;

    // system clock rate
    localparam int CLK_MHZ = 10;

    // bus style strap codes
    localparam logic [1:0] STYLE_6800_16 = 2'h3;
    localparam logic [1:0] STYLE_8080_16 = 2'h2;
    localparam logic [1:0] STYLE_6800_8 = 2'h1;
    localparam logic [1:0] STYLE_8080_8 = 2'h0;

    // mode sense codes {upper, lower} that pick the serial modes
    localparam logic [1:0] SENSE_SER_A = 2'h2;
    localparam logic [1:0] SENSE_SER_B = 2'h3;

    // data line positions with a special use
    localparam int SENSE_UPPER_BIT = 15;
    localparam int SENSE_LOWER_BIT = 13;
    localparam int SCK_BIT = 0;
    localparam int SDA_BIT = 8;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;

    // reset filter and power-on stretch, in ns and in cycles
    localparam int RST_FILTER_NS = 500;
    localparam int RST_FILTER_CYC = (RST_FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int POR_HOLD_NS = 2000;
    localparam int POR_HOLD_CYC = (POR_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;

    // reset value of the programmable identification flags
    localparam logic [1:0] ID_FLAGS_RST = 2'h0;

    // decoded interface mode
    typedef enum logic [2:0] {
        MODE_P6800_16 = 3'h0,
        MODE_P8080_16 = 3'h1,
        MODE_P6800_8 = 3'h2,
        MODE_P8080_8 = 3'h3,
        MODE_SER_4W = 3'h4,
        MODE_SER_COMPACT = 3'h5,
        MODE_SER_9BIT = 3'h6,
        MODE_RESERVED = 3'h7
    } mode_e;

    // reset sequencer states, gray coded along por -> run
    typedef enum logic [1:0] {
        RS_POR = 2'h0,
        RS_RUN = 2'h1,
        RS_HOLD = 2'h3
    } rst_state_e;

    // host pins as one bundle
    typedef struct packed {
        logic [1:0] bus_style_straps;
        logic select_active_low;
        logic select_active_high;
        logic [1:0] strobe;
        logic command_data_select;
        logic vendor_strap_a;
        logic byte_lane_strap;
        logic reset_pin_n;
        logic [DATA_W-1:0] data;
    } pins_s;

    localparam int PINS_W = $bits(pins_s);

endpackage

// ==== hw/pin_sync3.sv ====
// three-stage pin synchroniser with agreement filter
// assumes inputs come from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 import host_mode_pkg::*; #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // raw and filtered levels
    input wire logic [W-1:0] raw,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_s;

    sync_s st_ff;
    sync_s nxt_st;

    if (W < 1) begin : g_bad_width
        $error("pin_sync3 width must be at least 1");
    end

    // shift, and take a bit only when stages two and three agree
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = raw;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < W; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) nxt_st.q[i] = st_ff.s3[i];
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= {INIT, INIT, INIT, INIT};
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q;
endmodule
`default_nettype wire

// ==== hw/host_bus_front.sv ====
// host interface front end: mode straps, chip select, strobes, resets, id bits
// assumes one 10 MHz clock; host pins are asynchronous and pass pin_sync3
// Notes on behaviour
// [R1] bus style 11 or 10 gives 16-bit parallel, 6800 or 8080 strobes
// [R2] upper sense 0: style 01 is 6800 8-bit, style 00 is 8080 8-bit
// [R3] style 00 with sense 10 gives 4-wire serial, 8-bit tokens
// [R4] style 00 with sense 11 gives compact 3/4-wire serial, 8-bit tokens
// [R5] style 01 with sense 10 gives 3-wire serial with 9-bit tokens
// [R6] selected only while high select is high and low select is low
// [R7] all sixteen data lines float while not selected
// [R8] reset pin held low returns every control register to default
// [R9] power-on reset and software reset work without the reset pin
// [R10] reset pin is noise filtered inside, no outside network needed
// [R11] four readable id bits: two wired straps plus two programmable flags
// [R12] 8-bit modes take low lines or even lines per byte lane strap
// [R13] command/data select low is control, high is display data; unused in 9-bit
// [R14] serial modes use data line 0 as clock, line 8 as data
// [R15] status read returns the two wired strap levels
// [R16] strobe pins mean per bus style; unused in serial modes
// [R17] strobes and serial clock are ignored while not selected
// [R18] the system holds mode straps and sense lines static in operation
`timescale 1ns/1ps
`default_nettype none
module host_bus_front import host_mode_pkg::*; #(
    parameter int FILTER_CYC = RST_FILTER_CYC,
    parameter int POR_CYC = POR_HOLD_CYC
) (
    // clock, power-on reset, clock enable
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // host pins
    input wire pins_s PINS,
    // core side controls
    input wire logic SOFT_RESET,
    input wire logic ID_FLAG_WRITE,
    input wire logic [1:0] ID_FLAG_VALUE,
    input wire logic [DATA_W-1:0] READ_WORD,
    // data bus drive
    output logic [DATA_W-1:0] DATA_OUT,
    output logic [DATA_W-1:0] DATA_OE_N,
    // decoded interface state
    output mode_e MODE,
    output logic SELECTED,
    output logic CTRL_RESET_N,
    // parallel transfers
    output logic WRITE_PULSE,
    output logic READ_ACTIVE,
    output logic [DATA_W-1:0] WRITE_WORD,
    output logic DISPLAY_DATA,
    // serial lines
    output logic SERIAL_CLK,
    output logic SERIAL_DATA,
    output logic SERIAL_CD,
    // identification
    output logic [3:0] ID_BITS,
    output logic [1:0] STRAP_STATUS
);
    typedef struct packed {
        rst_state_e rs;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] low_cnt;
        logic ctrl_rst_n;
        mode_e mode;
        logic sel;
        logic [1:0] strobe_d;
        logic wr_pulse;
        logic rd_act;
        logic [DATA_W-1:0] wword;
        logic disp;
        logic sck;
        logic sda;
        logic scd;
        logic [1:0] id_flags;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] oe_n;
    } front_s;

    localparam pins_s PINS_INIT = '{reset_pin_n: 1'b1, default: '0};

    pins_s pin_q;
    front_s st_ff;
    front_s nxt_st;

    if (FILTER_CYC < 1 || FILTER_CYC >= (1 << CNT_W) ||
        POR_CYC < 1 || POR_CYC >= (1 << CNT_W)) begin : g_bad_counts
        $error("reset counts do not fit the counter width");
    end

    // synchronise every host pin
    pin_sync3 #(.W(PINS_W), .INIT(PINS_INIT)) u_sync (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CLK_EN),
        .raw(PINS),
        .q(pin_q)
    );

    // decode the interface mode from straps and sense lines
    function automatic mode_e decode_mode(input logic [1:0] style, input logic [1:0] sense);
        mode_e m;
        m = MODE_RESERVED;
        case (style)
            STYLE_6800_16: m = MODE_P6800_16; // R1
            STYLE_8080_16: m = MODE_P8080_16; // R1
            STYLE_6800_8: begin
                if (!sense[1]) m = MODE_P6800_8; // R2
                else if (sense == SENSE_SER_A) m = MODE_SER_9BIT; // R5
            end
            STYLE_8080_8: begin
                if (!sense[1]) m = MODE_P8080_8; // R2
                else if (sense == SENSE_SER_A) m = MODE_SER_4W; // R3
                else m = MODE_SER_COMPACT; // R4
            end
            default: m = MODE_RESERVED;
        endcase
        return m;
    endfunction

    // true for the two 8-bit parallel modes
    function automatic logic is_byte_mode(input mode_e m);
        return (m == MODE_P6800_8) || (m == MODE_P8080_8);
    endfunction

    // true for the three serial modes
    function automatic logic is_serial(input mode_e m);
        return (m == MODE_SER_4W) || (m == MODE_SER_COMPACT) || (m == MODE_SER_9BIT);
    endfunction

    // gather a byte from the bus, low lines or even lines
    function automatic logic [BYTE_W-1:0] take_byte(input logic [DATA_W-1:0] d,
                                                    input logic low_lane);
        logic [BYTE_W-1:0] b;
        b = '0;
        for (int i = 0; i < BYTE_W; i++) begin
            b[i] = low_lane ? d[i] : d[2*i];
        end
        return b;
    endfunction

    // place a byte on the bus lines used by the byte lane strap
    function automatic logic [DATA_W-1:0] put_byte(input logic [BYTE_W-1:0] b,
                                                   input logic low_lane);
        logic [DATA_W-1:0] d;
        d = '0;
        for (int i = 0; i < BYTE_W; i++) begin
            if (low_lane) d[i] = b[i];
            else d[2*i] = b[i];
        end
        return d;
    endfunction

    // next-state logic
    always_comb begin
        logic low_stable;
        logic par;
        logic sixty8;
        logic wr_evt;
        logic rd_now;
        logic [DATA_W-1:0] rword;
        low_stable = 1'b0;
        par = 1'b0;
        sixty8 = 1'b0;
        wr_evt = 1'b0;
        rd_now = 1'b0;
        rword = '0;
        nxt_st = st_ff;
        nxt_st.wr_pulse = 1'b0;

        // reset pin filter: low for FILTER_CYC cycles counts as reset
        if (pin_q.reset_pin_n) begin
            nxt_st.low_cnt = '0; // R10
        end else if (st_ff.low_cnt < CNT_W'(FILTER_CYC)) begin
            nxt_st.low_cnt = st_ff.low_cnt + CNT_W'(1); // R10
        end
        low_stable = (st_ff.low_cnt >= CNT_W'(FILTER_CYC));

        // reset sequencer: power-on stretch, pin hold, software reset
        case (st_ff.rs)
            RS_POR: begin
                nxt_st.ctrl_rst_n = 1'b0;
                if (st_ff.cnt >= CNT_W'(POR_CYC - 1)) begin
                    nxt_st.rs = RS_RUN; // R9
                    nxt_st.ctrl_rst_n = 1'b1;
                    nxt_st.cnt = '0;
                end else begin
                    nxt_st.cnt = st_ff.cnt + CNT_W'(1);
                end
            end
            RS_RUN: begin
                nxt_st.ctrl_rst_n = 1'b1;
                if (low_stable) begin
                    nxt_st.rs = RS_HOLD; // R8
                    nxt_st.ctrl_rst_n = 1'b0;
                end else if (SOFT_RESET) begin
                    nxt_st.rs = RS_POR; // R9
                    nxt_st.ctrl_rst_n = 1'b0;
                    nxt_st.cnt = '0;
                end
            end
            RS_HOLD: begin
                nxt_st.ctrl_rst_n = 1'b0;
                if (pin_q.reset_pin_n) begin
                    nxt_st.rs = RS_RUN; // R8
                    nxt_st.ctrl_rst_n = 1'b1;
                end
            end
            default: begin
                nxt_st.rs = RS_POR;
                nxt_st.ctrl_rst_n = 1'b0;
                nxt_st.cnt = '0;
            end
        endcase

        // mode and selection
        nxt_st.mode = decode_mode(pin_q.bus_style_straps,
                                  {pin_q.data[SENSE_UPPER_BIT], pin_q.data[SENSE_LOWER_BIT]});
        nxt_st.sel = pin_q.select_active_high && !pin_q.select_active_low; // R6
        par = !is_serial(st_ff.mode) && (st_ff.mode != MODE_RESERVED);
        sixty8 = (st_ff.mode == MODE_P6800_16) || (st_ff.mode == MODE_P6800_8);
        nxt_st.strobe_d = pin_q.strobe;

        // strobe meaning: 6800 strobe0 enable, strobe1 read/write;
        // 8080 strobe0 write low, strobe1 read low
        if (sixty8) begin
            wr_evt = st_ff.strobe_d[0] && !pin_q.strobe[0] && !pin_q.strobe[1]; // R16
            rd_now = pin_q.strobe[0] && pin_q.strobe[1]; // R16
        end else begin
            wr_evt = !st_ff.strobe_d[0] && pin_q.strobe[0]; // R16
            rd_now = !pin_q.strobe[1]; // R16
        end

        // parallel write capture, only when selected
        if (par && st_ff.sel && wr_evt && st_ff.ctrl_rst_n) begin // R17
            nxt_st.wr_pulse = 1'b1;
            nxt_st.disp = pin_q.command_data_select; // R13
            if (is_byte_mode(st_ff.mode)) begin
                nxt_st.wword = {{(DATA_W-BYTE_W){1'b0}},
                                take_byte(pin_q.data, pin_q.byte_lane_strap)}; // R12
            end else begin
                nxt_st.wword = pin_q.data; // R1
            end
        end
        nxt_st.rd_act = par && st_ff.sel && rd_now && st_ff.ctrl_rst_n; // R17

        // read drive and bus float
        if (is_byte_mode(st_ff.mode)) begin
            rword = put_byte(READ_WORD[BYTE_W-1:0], pin_q.byte_lane_strap); // R12
        end else begin
            rword = READ_WORD;
        end
        nxt_st.dout = nxt_st.rd_act ? rword : '0;
        nxt_st.oe_n = nxt_st.rd_act ? '0 : '1; // R7

        // serial lines pass only while selected in a serial mode
        if (is_serial(st_ff.mode) && st_ff.sel) begin // R17
            nxt_st.sck = pin_q.data[SCK_BIT]; // R14
            nxt_st.sda = pin_q.data[SDA_BIT]; // R14
            nxt_st.scd = (st_ff.mode == MODE_SER_9BIT) ? 1'b0 : pin_q.command_data_select; // R13
        end else begin
            nxt_st.sck = 1'b0;
            nxt_st.sda = 1'b0;
            nxt_st.scd = 1'b0;
        end

        // programmable id flags, back to default on any control reset
        if (!st_ff.ctrl_rst_n) begin
            nxt_st.id_flags = ID_FLAGS_RST; // R8
        end else if (ID_FLAG_WRITE) begin
            nxt_st.id_flags = ID_FLAG_VALUE; // R11
        end
    end

    // state register
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st_ff <= '{rs: RS_POR, mode: MODE_RESERVED, id_flags: ID_FLAGS_RST,
                       oe_n: '1, default: '0};
        end else if (CLK_EN) begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register; strap bits straight from the synchroniser
    assign DATA_OUT = st_ff.dout;
    assign DATA_OE_N = st_ff.oe_n;
    assign MODE = st_ff.mode;
    assign SELECTED = st_ff.sel;
    assign CTRL_RESET_N = st_ff.ctrl_rst_n;
    assign WRITE_PULSE = st_ff.wr_pulse;
    assign READ_ACTIVE = st_ff.rd_act;
    assign WRITE_WORD = st_ff.wword;
    assign DISPLAY_DATA = st_ff.disp;
    assign SERIAL_CLK = st_ff.sck;
    assign SERIAL_DATA = st_ff.sda;
    assign SERIAL_CD = st_ff.scd;
    assign ID_BITS = {st_ff.id_flags, pin_q.byte_lane_strap, pin_q.vendor_strap_a}; // R11
    assign STRAP_STATUS = {pin_q.byte_lane_strap, pin_q.vendor_strap_a}; // R15
endmodule
`default_nettype wire

// ==== verif/host_front_checker.sv ====
// checker for the host front end: relations between its ports over time
// assumes it is bound to host_bus_front and given the same counts
`timescale 1ns/1ps
`default_nettype none
module host_front_checker import host_mode_pkg::*; #(
    parameter int FILTER_CYC = 3,
    parameter int POR_CYC = 3
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // core side control
    input wire logic SOFT_RESET,
    // watched outputs
    input wire logic [DATA_W-1:0] DATA_OE_N,
    input wire mode_e MODE,
    input wire logic SELECTED,
    input wire logic CTRL_RESET_N,
    input wire logic WRITE_PULSE,
    input wire logic READ_ACTIVE,
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_DATA,
    input wire logic SERIAL_CD,
    input wire logic [3:0] ID_BITS,
    input wire logic [1:0] STRAP_STATUS
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    // bus floats once deselect has passed the output flops
    chk_float_unsel: assert property (
        !SELECTED && !$past(SELECTED) && !$past(SELECTED, 2) |-> &DATA_OE_N)
        else $error("data bus driven while not selected");
    // lines are driven only by a read
    chk_drive_read: assert property (!(&DATA_OE_N) |-> READ_ACTIVE)
        else $error("data bus driven without a read");
    // a write pulse lasts one cycle
    chk_pulse_one: assert property (WRITE_PULSE |=> !WRITE_PULSE)
        else $error("write pulse longer than one cycle");
    // writes only when selected, out of reset and in a parallel mode
    chk_write_sel: assert property (
        WRITE_PULSE |-> $past(SELECTED) && $past(CTRL_RESET_N) && MODE < MODE_SER_4W)
        else $error("write taken while not allowed");
    // serial lines stay quiet while not selected
    chk_serial_quiet: assert property (
        !SELECTED && !$past(SELECTED) |-> !SERIAL_CLK && !SERIAL_DATA && !SERIAL_CD)
        else $error("serial activity while not selected");
    // nine bit serial ignores command/data select
    chk_cd_nine: assert property (
        MODE == MODE_SER_9BIT && $past(MODE) == MODE_SER_9BIT |-> !SERIAL_CD)
        else $error("command flag seen in nine bit mode");
    // id bits carry the wired straps
    chk_id_straps: assert property (ID_BITS[1:0] == STRAP_STATUS)
        else $error("id straps differ from status field");
    // control reset clears the programmable flags
    chk_id_clear: assert property (
        !CTRL_RESET_N |=> ID_BITS[3:2] == ID_FLAGS_RST)
        else $error("id flags kept through reset");
    // software reset holds the control registers in reset
    chk_soft_reset: assert property (
        SOFT_RESET && CLK_EN |=> !CTRL_RESET_N [*2])
        else $error("software reset not applied");

    // main scenarios
    cov_write: cover property (WRITE_PULSE);
    cov_read: cover property (READ_ACTIVE);
    cov_serial: cover property ($rose(SERIAL_CLK));
    cov_soft: cover property (SOFT_RESET ##1 !CTRL_RESET_N);
endmodule

bind host_bus_front host_front_checker #(.FILTER_CYC(FILTER_CYC), .POR_CYC(POR_CYC)) i_chk (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CLK_EN(CLK_EN), .SOFT_RESET(SOFT_RESET),
    .DATA_OE_N(DATA_OE_N), .MODE(MODE), .SELECTED(SELECTED), .CTRL_RESET_N(CTRL_RESET_N),
    .WRITE_PULSE(WRITE_PULSE), .READ_ACTIVE(READ_ACTIVE), .SERIAL_CLK(SERIAL_CLK),
    .SERIAL_DATA(SERIAL_DATA), .SERIAL_CD(SERIAL_CD), .ID_BITS(ID_BITS),
    .STRAP_STATUS(STRAP_STATUS));
`default_nettype wire

// ==== verif/host_cpu_model.sv ====
// host processor model: drives the host pins and releases the data bus
// assumes the bench moves straps and selects through drv, keep and strap_en
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model import host_mode_pkg::*; (
    // clock
    input wire logic clk,
    // device drive of the data bus
    input wire logic [DATA_W-1:0] dev_out,
    input wire logic [DATA_W-1:0] dev_oe_n,
    // pins seen by the device
    output var pins_s pins
);
    pins_s drv;
    logic [DATA_W-1:0] host_d = 16'h0000;
    logic host_en = 1'b0;
    logic [1:0] keep = 2'h0;
    logic strap_en = 1'b0;
    logic [DATA_W-1:0] bus;
    // start deselected with the reset pin released
    initial begin
        drv = '0;
        drv.select_active_low = 1'b1;
        drv.reset_pin_n = 1'b1;
    end
    // wire level: device, else host, else inverse of the last host value
    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            bus[i] = !dev_oe_n[i] ? dev_out[i] : (host_en ? host_d[i] : !host_d[i]);
        end
        if (strap_en) begin
            bus[SENSE_UPPER_BIT] = keep[1];
            bus[SENSE_LOWER_BIT] = keep[0];
        end
        pins = drv;
        pins.data = bus;
    end
    // one write: data settles, strobe held 4 cycles, data kept past the edge
    task automatic put(input logic m6800, input logic [15:0] w, input logic cd);
        @(posedge clk);
        host_d <= w;
        host_en <= 1'b1;
        drv.command_data_select <= cd;
        repeat (4) @(posedge clk);
        drv.strobe <= m6800 ? 2'b01 : 2'b10;
        repeat (4) @(posedge clk);
        drv.strobe <= m6800 ? 2'b00 : 2'b11;
        repeat (8) @(posedge clk);
        host_en <= 1'b0;
    endtask
    // one read: sample the wire late in the strobe, then release;
    // 6800 keeps read/write high as enable falls so the release is no write
    task automatic get(input logic m6800, output logic [15:0] r);
        @(posedge clk);
        host_en <= 1'b0;
        drv.strobe <= m6800 ? 2'b11 : 2'b01;
        repeat (8) @(posedge clk);
        @(negedge clk);
        r = bus;
        @(posedge clk);
        drv.strobe <= m6800 ? 2'b10 : 2'b11;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== verif/host_bus_mode_select_tb.sv ====
// bench for the host front end: reference model, host model, bound checker
// assumes short reset counts are safe for the filter and power-on stretch
`timescale 1ns/1ps
`default_nettype none
module host_bus_mode_select_tb import host_mode_pkg::*; ;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic soft_reset = 1'b0;
    logic id_wr = 1'b0;
    logic [1:0] id_val = 2'h0;
    logic [15:0] rd_word = 16'h0000;
    logic [15:0] data_out, oe_n, wr_word, w, r;
    mode_e mode;
    logic selected, ctrl_rst_n, wr_pulse, rd_act, disp, s_clk, s_dat, s_cd, cd;
    logic [3:0] id_bits;
    logic [1:0] straps, s;
    pins_s pins;
    int failures = 0;
    int comparisons = 0;
    int lowcnt = 0;
    int n;
    logic [16:0] expq[$];
    logic [16:0] m;

    host_bus_front #(.FILTER_CYC(3), .POR_CYC(3)) i_dut (
        .CLK_SYS(clk), .RST_N(rst_n), .CLK_EN(clk_en), .PINS(pins),
        .SOFT_RESET(soft_reset), .ID_FLAG_WRITE(id_wr), .ID_FLAG_VALUE(id_val),
        .READ_WORD(rd_word), .DATA_OUT(data_out), .DATA_OE_N(oe_n), .MODE(mode),
        .SELECTED(selected), .CTRL_RESET_N(ctrl_rst_n), .WRITE_PULSE(wr_pulse),
        .READ_ACTIVE(rd_act), .WRITE_WORD(wr_word), .DISPLAY_DATA(disp),
        .SERIAL_CLK(s_clk), .SERIAL_DATA(s_dat), .SERIAL_CD(s_cd),
        .ID_BITS(id_bits), .STRAP_STATUS(straps));
    host_cpu_model i_host (.clk(clk), .dev_out(data_out), .dev_oe_n(oe_n), .pins(pins));

    // 10 MHz clock
    initial forever #50 clk = ~clk;

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        @(negedge clk);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // reference decode of straps and sense lines
    function automatic int exp_mode(input int st, input int se);
        if (st > 1) return st == 3 ? 0 : 1;
        if (se < 2) return st == 1 ? 2 : 3;
        if (st == 0) return se == 2 ? 4 : 5;
        return se == 2 ? 6 : 7;
    endfunction
    // byte placed on low lines or on even lines
    function automatic logic [15:0] lane(input logic [7:0] b, input logic ln);
        logic [15:0] d;
        d = 16'h0000;
        for (int i = 0; i < 8; i++) d[ln ? i : 2 * i] = b[i];
        return d;
    endfunction
    task automatic set_mode(input int st, input int se);
        @(posedge clk);
        i_host.drv.bus_style_straps <= 2'(st);
        i_host.drv.strobe <= st[0] ? 2'b00 : 2'b11;
        i_host.keep <= 2'(se);
        i_host.strap_en <= st < 2;
        repeat (8) @(posedge clk);
    endtask
    task automatic sel(input logic on);
        @(posedge clk);
        i_host.drv.select_active_high <= on;
        i_host.drv.select_active_low <= !on;
        repeat (8) @(posedge clk);
    endtask

    // every write pulse must match the oldest write the host made
    always @(negedge clk) begin
        if (wr_pulse === 1'b1) begin
            m = expq.size() > 0 ? expq.pop_front() : 17'h1FFFF;
            check({disp, wr_word}, m);
        end
        if (ctrl_rst_n === 1'b0) lowcnt++;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        conclude();
    end

    initial begin
        void'($urandom(32'h1359));
        repeat (10) @(posedge clk);
        check({oe_n, ctrl_rst_n}, 17'h1FFFE);
        check(17'({mode, rd_act, wr_pulse}), 17'h1C);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge clk);
        for (int st = 0; st < 4; st++) begin
            for (int se = 0; se < 4; se++) begin
                set_mode(st, se);
                check(17'(mode), 17'(exp_mode(st, se)));
            end
        end
        set_mode(2, 0);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            i_host.drv.select_active_high <= k[1];
            i_host.drv.select_active_low <= k[0];
            repeat (8) @(posedge clk);
            check({selected, oe_n}, {k == 2, 16'hFFFF});
        end
        i_host.put(1'b0, 16'h1234, 1'b1);
        sel(1'b1);
        for (int st = 0; st < 4; st++) begin
            for (int ln = 0; ln < 2; ln++) begin
                set_mode(st, 0);
                i_host.drv.byte_lane_strap <= ln[0];
                w = 16'($urandom);
                cd = 1'($urandom);
                expq.push_back({cd, st > 1 ? w : {8'h00, w[7:0]}});
                i_host.put(st[0], st > 1 ? w : lane(w[7:0], ln[0]), cd);
            end
        end
        for (int st = 2; st < 4; st++) begin
            set_mode(st, 0);
            rd_word <= 16'($urandom);
            i_host.get(st[0], r);
            check(17'(r), 17'(rd_word));
        end
        sel(1'b0);
        i_host.put(1'b1, 16'h5A5A, 1'b1);
        check(17'(expq.size()), 17'h0);
        for (int k = 0; k < 3; k++) begin
            set_mode(k / 2, 2 + k % 2);
            sel(1'b1);
            w = 16'($urandom);
            cd = 1'($urandom);
            i_host.host_d <= w;
            i_host.host_en <= 1'b1;
            i_host.drv.command_data_select <= cd;
            repeat (8) @(posedge clk);
            check(17'({s_clk, s_dat, s_cd}), 17'({w[0], w[8], cd && k < 2}));
            sel(1'b0);
            check(17'({s_clk, s_dat, s_cd}), 17'h0);
        end
        @(posedge clk);
        i_host.drv.vendor_strap_a <= 1'($urandom);
        id_val <= 2'($urandom);
        id_wr <= 1'b1;
        @(posedge clk);
        id_wr <= 1'b0;
        repeat (8) @(posedge clk);
        s = {i_host.drv.byte_lane_strap, i_host.drv.vendor_strap_a};
        check(17'({id_bits, straps}), 17'({id_val, s, s}));
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        @(posedge clk);
        check(17'({ctrl_rst_n, id_bits[3:2]}), 17'h0);
        for (int k = 0; k < 2; k++) begin
            repeat (8) @(posedge clk);
            n = lowcnt;
            i_host.drv.reset_pin_n <= 1'b0;
            repeat (k ? 12 : 1) @(posedge clk);
            i_host.drv.reset_pin_n <= 1'b1;
            repeat (20) @(posedge clk);
            check(17'({lowcnt > n, ctrl_rst_n}), 17'({k[0], 1'b1}));
        end
        conclude();
    end
endmodule
`default_nettype wire
